/* core/tmr8w_core.sv */
`timescale 1ns/1ps

// Contract
// - Normal mode increments only, wraps to zero.
// - Normal overflow flag sets as counter becomes zero.
// - Compare output fields never alter counting.
// - Clear-on-compare clears counter on compare A match.
// - Clear-on-compare compare A written directly, unbuffered.
// - Clear-on-compare toggle inverts output A per match.
// - Clear-on-compare overflow sets on max-to-zero pass.
// - Fast PWM single slope; top per mode.
// - Fast PWM value two/three clear/set polarity.
// - Fast PWM clears after top, bottom action same.
// - Fast PWM overflow sets at every top.
// - Fast PWM toggle only channel A, upper bit.
// - Pin shows output only when direction is output.
// - Fast PWM extremes: spike or constant level.
// - Fast PWM toggle uses buffered compare values.
// - Phase-correct counts up then down; top per mode.
// - Phase-correct clears up-match, sets down-match, invertible.
// - Phase-correct holds top one cycle, then reverses.
// - Phase-correct overflow sets on reaching bottom.
// - Phase-correct extremes give constant levels.
// - Phase-correct toggle only channel A, upper bit.
// - Phase-correct forces symmetric level at bottom.
// - PWM compare values buffered, others immediate.
// - Match sets compare flag; write one clears.
// - Reset clears both waveform output states.
module tmr8w_core
    import tmr8w_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       timer_tick,
    input  wire logic [2:0] waveform_mode_field,
    input  wire logic [1:0] compare_output_field_a,
    input  wire logic [1:0] compare_output_field_b,
    input  wire logic [7:0] compare_a_wdata,
    input  wire logic       compare_a_wr,
    input  wire logic [7:0] compare_b_wdata,
    input  wire logic       compare_b_wr,
    input  wire logic [7:0] counter_wdata,
    input  wire logic       counter_wr,
    input  wire logic       overflow_clr,
    input  wire logic       compare_flag_a_clr,
    input  wire logic       compare_flag_b_clr,
    input  wire logic       data_dir_a,
    input  wire logic       data_dir_b,
    input  wire logic       port_data_a,
    input  wire logic       port_data_b,
    output logic      [7:0] counter_value,
    output logic            count_down,
    output logic      [7:0] compare_register_a,
    output logic      [7:0] compare_register_b,
    output logic            overflow_flag,
    output logic            compare_flag_a,
    output logic            compare_flag_b,
    output logic            waveform_output_a,
    output logic            waveform_output_b,
    output logic            pin_a_out,
    output logic            pin_a_oe,
    output logic            pin_b_out,
    output logic            pin_b_oe
);

    // ------------------------------------------------------------------------
    // Channel views of the per-channel ports.
    // ------------------------------------------------------------------------
    logic [1:0] com_w     [NUM_CH];   // Compare output field per channel.
    logic [7:0] wdata_w   [NUM_CH];   // Compare write data per channel.
    logic       wr_w      [NUM_CH];   // Compare write strobe per channel.
    logic       fclr_w    [NUM_CH];   // Compare flag clear per channel.
    logic       ddir_w    [NUM_CH];   // Pin direction per channel.
    logic       pdata_w   [NUM_CH];   // Plain port level per channel.
    logic [7:0] ocr_act_q [NUM_CH];   // Compare value the comparator uses.
    logic [7:0] ocr_buf_q [NUM_CH];   // Compare value software wrote last.
    logic       wave_q    [NUM_CH];   // Internal waveform output state.
    logic       wave_d    [NUM_CH];   // Next waveform output state.
    logic       flag_q    [NUM_CH];   // Sticky compare flag.
    logic       match_w   [NUM_CH];   // Unblocked compare match.
    logic       ovrd_w    [NUM_CH];   // Waveform drives the pin level.
    logic       pin_w     [NUM_CH];   // Level presented at the pin.

    assign com_w[0]   = compare_output_field_a;
    assign com_w[1]   = compare_output_field_b;
    assign wdata_w[0] = compare_a_wdata;
    assign wdata_w[1] = compare_b_wdata;
    assign wr_w[0]    = compare_a_wr;
    assign wr_w[1]    = compare_b_wr;
    assign fclr_w[0]  = compare_flag_a_clr;
    assign fclr_w[1]  = compare_flag_b_clr;
    assign ddir_w[0]  = data_dir_a;
    assign ddir_w[1]  = data_dir_b;
    assign pdata_w[0] = port_data_a;
    assign pdata_w[1] = port_data_b;

    // ------------------------------------------------------------------------
    // Mode decode. Only the waveform mode field feeds the mode decode; compare A also sets top.
    // ------------------------------------------------------------------------
    logic [7:0] counter_q;     // Counter value.
    tmr8w_dir_t dir_q;         // Dual-slope direction.
    logic       block_q;       // Counter write blocks the next tick's match.
    logic       ovf_q;         // Sticky overflow flag.

    wire logic [2:0] mode    = waveform_mode_field;
    wire logic       upper   = mode[MODE_UPPER_BIT];
    wire logic       is_ctc  = (mode == MODE_CTC);
    wire logic       is_fast = (mode == MODE_FAST_MAX) || (mode == MODE_FAST_OCR);
    wire logic       is_pc   = (mode == MODE_PC_MAX) || (mode == MODE_PC_OCR);
    // Codes 4 and 6 decode as none of the above, so they count as normal.
    wire logic       is_pwm  = is_fast || is_pc;

    // Top is channel A's active compare value in the upper PWM modes.
    wire logic [7:0] top_val   = (is_pwm && upper) ? ocr_act_q[CH_A] : CNT_MAX;
    wire logic       at_top    = (counter_q == top_val);
    wire logic       at_bottom = (counter_q == CNT_BOTTOM);

    // A counter write has priority over counting in the same cycle.
    wire logic tick_ok = timer_tick && !counter_wr;

    // ------------------------------------------------------------------------
    // Count sequence.
    // ------------------------------------------------------------------------
    // Fast PWM restarts from bottom on the tick after top was reached.
    wire logic fast_wrap   = is_fast && at_top;
    // Clear-on-compare uses the live compare A value, so a value written below
    // the count is missed until the counter wraps past max.
    wire logic ctc_clear   = is_ctc && (counter_q == ocr_act_q[CH_A]);
    wire logic pc_turn_top = is_pc && (dir_q == DIR_UP) && at_top;
    wire logic pc_turn_bot = is_pc && (dir_q == DIR_DOWN) && at_bottom;
    // Top is held for one tick, then the count steps down.
    wire logic pc_down     = is_pc && !at_bottom && ((dir_q == DIR_DOWN) || at_top);
    // A top of zero would trap the dual slope; the count just stays put then.
    wire logic pc_hold     = is_pc && at_top && at_bottom;

    // The carry and borrow are dropped on purpose: the count wraps in 8 bits.
    wire logic [7:0] cnt_inc  = 8'(counter_q + CNT_STEP);
    wire logic [7:0] cnt_dec  = 8'(counter_q - CNT_STEP);
    // Normal mode only increments and wraps by overrun.
    wire logic [7:0] cnt_next = (fast_wrap || ctc_clear) ? CNT_BOTTOM :
                                pc_hold                  ? counter_q  :
                                pc_down                  ? cnt_dec    : cnt_inc;

    // Overflow per mode: max-to-zero in non-PWM, top in fast, bottom in dual.
    wire logic ovf_nonpwm = !is_pwm && (counter_q == CNT_MAX);
    wire logic ovf_fast   = fast_wrap;
    wire logic ovf_pc     = is_pc && (dir_q == DIR_DOWN) && !at_bottom &&
                            (cnt_next == CNT_BOTTOM);
    wire logic ovf_set    = tick_ok && (ovf_nonpwm || ovf_fast || ovf_pc);

    // PWM modes move the buffered compare values in at the cycle update point.
    wire logic ocr_load   = tick_ok && (fast_wrap || pc_turn_top);

    // Counter, direction and write blocking.
    always_ff @(posedge mclk) begin
        if (srst) begin
            counter_q <= RST_COUNT;
            dir_q     <= DIR_UP;
            block_q   <= 1'b0;
        end else if (counter_wr) begin
            counter_q <= counter_wdata;
            block_q   <= 1'b1;
        end else if (timer_tick) begin
            counter_q <= cnt_next;
            block_q   <= 1'b0;
            if (!is_pc || pc_turn_bot) begin
                dir_q <= DIR_UP;
            end else if (pc_turn_top && !at_bottom) begin
                dir_q <= DIR_DOWN;
            end
        end
    end

    // Overflow flag; a set in the clearing cycle wins over the clear.
    always_ff @(posedge mclk) begin
        if (srst) begin
            ovf_q <= RST_FLAG;
        end else begin
            ovf_q <= ovf_set || (ovf_q && !overflow_clr);
        end
    end

    // ------------------------------------------------------------------------
    // Compare channels.
    // ------------------------------------------------------------------------
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        // Toggle is offered to both channels outside PWM; in PWM only to channel A, and only with the upper bit.
        wire logic tog_ok  = !is_pwm || ((ch == CH_A) && upper);
        wire logic com_tog = (com_w[ch] == COM_TOGGLE) && tog_ok;
        wire logic lvl_up  = com_w[ch][0];   // Up-match result: 2 clears, 3 sets.
        wire logic lvl_dn  = !com_w[ch][0];  // Down-match and bottom result.
        wire logic ocr_top = (ocr_act_q[ch] == top_val);
        wire logic ocr_zero = (ocr_act_q[ch] == CNT_BOTTOM);

        assign match_w[ch] = (counter_q == ocr_act_q[ch]) && !block_q;

        // Next output state for one timer tick.
        always_comb begin
            wave_d[ch] = wave_q[ch];
            if (!is_pwm) begin
                if (match_w[ch]) begin
                    case (com_w[ch])
                        COM_TOGGLE: wave_d[ch] = !wave_q[ch];
                        COM_CLEAR:  wave_d[ch] = 1'b0;
                        COM_SET:    wave_d[ch] = 1'b1;
                        default:    wave_d[ch] = wave_q[ch];
                    endcase
                end
            end else if (com_tog) begin
                // Buffered compare values drive the PWM toggle option.
                if (match_w[ch]) begin
                    wave_d[ch] = !wave_q[ch];
                end
            end else if (com_w[ch][1] && is_fast) begin
                // Bottom action wins; a match at top is ignored.
                if (fast_wrap) begin
                    wave_d[ch] = lvl_dn;
                end else if (match_w[ch] && !ocr_top) begin
                    wave_d[ch] = lvl_up;
                end
            end else if (com_w[ch][1]) begin
                // Bottom restores the level due below the compare value.
                if (at_bottom) begin
                    wave_d[ch] = ocr_zero ? lvl_up : lvl_dn;
                end else if (ocr_top && at_top) begin
                    wave_d[ch] = lvl_dn;
                end else if (match_w[ch]) begin
                    wave_d[ch] = (dir_q == DIR_UP) ? lvl_up : lvl_dn;
                end
            end
        end

        // Compare values: immediate outside PWM, double buffered inside it.
        always_ff @(posedge mclk) begin
            if (srst) begin
                ocr_buf_q[ch] <= RST_COMPARE;
                ocr_act_q[ch] <= RST_COMPARE;
            end else begin
                if (wr_w[ch]) begin
                    ocr_buf_q[ch] <= wdata_w[ch];
                end
                if (wr_w[ch] && !is_pwm) begin
                    ocr_act_q[ch] <= wdata_w[ch];
                end else if (ocr_load || !is_pwm) begin
                    ocr_act_q[ch] <= ocr_buf_q[ch];
                end
            end
        end

        // Output state and sticky compare flag.
        always_ff @(posedge mclk) begin
            if (srst) begin
                wave_q[ch] <= RST_WAVE;
                flag_q[ch] <= RST_FLAG;
            end else begin
                if (tick_ok) begin
                    wave_q[ch] <= wave_d[ch];
                end
                flag_q[ch] <= (tick_ok && match_w[ch]) ||
                              (flag_q[ch] && !fclr_w[ch]);
            end
        end

        // The waveform overrides the port level unless the field disconnects it.
        assign ovrd_w[ch] = (com_w[ch] != COM_OFF) &&
                            !((com_w[ch] == COM_TOGGLE) && !tog_ok);
        assign pin_w[ch]  = ovrd_w[ch] ? wave_q[ch] : pdata_w[ch];
    end

    // ------------------------------------------------------------------------
    // Outputs. The driver only turns on when the direction bit says output.
    // ------------------------------------------------------------------------
    assign counter_value      = counter_q;
    assign count_down         = (dir_q == DIR_DOWN);
    assign compare_register_a = ocr_act_q[0];
    assign compare_register_b = ocr_act_q[1];
    assign overflow_flag      = ovf_q;
    assign compare_flag_a     = flag_q[0];
    assign compare_flag_b     = flag_q[1];
    assign waveform_output_a  = wave_q[0];
    assign waveform_output_b  = wave_q[1];
    assign pin_a_out          = pin_w[0];
    assign pin_b_out          = pin_w[1];
    assign pin_a_oe           = data_dir_a;
    assign pin_b_oe           = data_dir_b;

    // ------------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------------
    property p_normal_wrap;
        @(posedge mclk) disable iff (srst)
        (tick_ok && mode == MODE_NORMAL && counter_q == CNT_MAX)
            |=> (counter_value == CNT_BOTTOM) && overflow_flag;
    endproperty
    a_normal_wrap: assert property (p_normal_wrap)
        else $error("normal mode did not wrap with overflow");

    property p_ovf_sticky;
        @(posedge mclk) disable iff (srst)
        (overflow_flag && !overflow_clr) |=> overflow_flag;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky)
        else $error("overflow flag cleared without a clear");

    property p_ctc_clear;
        @(posedge mclk) disable iff (srst)
        (tick_ok && is_ctc && counter_q == compare_register_a)
            |=> (counter_value == CNT_BOTTOM);
    endproperty
    a_ctc_clear: assert property (p_ctc_clear)
        else $error("clear-on-compare did not clear the counter");

    property p_ctc_toggle;
        @(posedge mclk) disable iff (srst)
        (tick_ok && is_ctc && compare_output_field_a == COM_TOGGLE && match_w[0])
            |=> (waveform_output_a != $past(waveform_output_a));
    endproperty
    a_ctc_toggle: assert property (p_ctc_toggle)
        else $error("output A did not toggle on match");

    property p_fast_wrap;
        @(posedge mclk) disable iff (srst)
        (tick_ok && is_fast && counter_q == top_val && compare_output_field_b[1])
            |=> (counter_value == CNT_BOTTOM) &&
                (waveform_output_b == !$past(compare_output_field_b[0]));
    endproperty
    a_fast_wrap: assert property (p_fast_wrap)
        else $error("fast PWM wrap or bottom action wrong");

    property p_pc_hold_top;
        @(posedge mclk) disable iff (srst)
        (tick_ok && pc_turn_top && !at_bottom)
            |=> count_down && (counter_value == 8'($past(top_val) - CNT_STEP));
    endproperty
    a_pc_hold_top: assert property (p_pc_hold_top)
        else $error("dual slope did not reverse after top");

    property p_pc_ovf;
        @(posedge mclk) disable iff (srst)
        (tick_ok && is_pc && count_down && counter_q == CNT_STEP) |=> overflow_flag;
    endproperty
    a_pc_ovf: assert property (p_pc_ovf)
        else $error("dual slope overflow missing at bottom");

    property p_cmp_flag;
        @(posedge mclk) disable iff (srst)
        (tick_ok && match_w[1]) |=> compare_flag_b;
    endproperty
    a_cmp_flag: assert property (p_cmp_flag)
        else $error("compare flag B not set after match");

    property p_reset_wave;
        @(posedge mclk)
        srst |=> !waveform_output_a && !waveform_output_b;
    endproperty
    a_reset_wave: assert property (p_reset_wave)
        else $error("waveform state not cleared by reset");

    // A connected field must route the internal state, while only the direction bit
    // decides whether the driver is on.
    property p_pin_hidden;
        @(posedge mclk) disable iff (srst)
        compare_output_field_a[1]
            |-> (pin_a_out == waveform_output_a) && (pin_a_oe == data_dir_a);
    endproperty
    a_pin_hidden: assert property (p_pin_hidden)
        else $error("pin A level or driver enable wrong");

    c_ctc_toggle: cover property (@(posedge mclk) disable iff (srst)
        tick_ok && is_ctc && match_w[0] && compare_output_field_a == COM_TOGGLE);
    c_fast_wrap: cover property (@(posedge mclk) disable iff (srst)
        tick_ok && fast_wrap);
    c_pc_turn: cover property (@(posedge mclk) disable iff (srst)
        tick_ok && pc_turn_top ##[1:600] tick_ok && pc_turn_bot);
    c_ovf_clear: cover property (@(posedge mclk) disable iff (srst)
        overflow_flag && overflow_clr);

endmodule

/* core/tmr8w_pkg.sv */
// ----------------------------------------------------------------------------
// Shared constants of the 8-bit waveform timer.
// ----------------------------------------------------------------------------
package tmr8w_pkg;

    // Counter width and the two extreme count values.
    localparam int        CNT_W      = 8;
    localparam logic [7:0] CNT_MAX    = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_STEP   = 8'h01;

    // Number of compare channels; channel 0 is A, channel 1 is B.
    localparam int NUM_CH = 2;
    localparam int CH_A   = 0;

    // Waveform mode codes; 4 and 6 fall back to normal counting.
    localparam logic [2:0] MODE_NORMAL   = 3'h0;
    localparam logic [2:0] MODE_PC_MAX   = 3'h1;
    localparam logic [2:0] MODE_CTC      = 3'h2;
    localparam logic [2:0] MODE_FAST_MAX = 3'h3;
    localparam logic [2:0] MODE_PC_OCR   = 3'h5;
    localparam logic [2:0] MODE_FAST_OCR = 3'h7;
    localparam int         MODE_UPPER_BIT = 2;

    // Compare output field codes.
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    // Reset values of the stored state.
    localparam logic [7:0] RST_COUNT   = 8'h00;
    localparam logic [7:0] RST_COMPARE = 8'h00;
    localparam logic       RST_WAVE    = 1'b0;
    localparam logic       RST_FLAG    = 1'b0;

    // Count direction of the dual-slope mode.
    typedef enum logic {
        DIR_UP,
        DIR_DOWN
    } tmr8w_dir_t;

endpackage

/* testbench/tb.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Self-checking bench for the 8-bit waveform timer.
// ----------------------------------------------------------------------------
module tb
    import tmr8w_pkg::*;
;
    // Stimulus, all given a value at time zero.
    logic       mclk = 1'b0, srst = 1'b1, tick_en = 1'b0, flag_clr = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [1:0] com_a = 2'h0, com_b = 2'h0;
    logic [7:0] cmp_a_d = 8'h00, cmp_b_d = 8'h00, cnt_d = 8'h00;
    logic       cmp_a_we = 1'b0, cmp_b_we = 1'b0, cnt_we = 1'b0;
    logic       dir_a = 1'b1, dir_b = 1'b0, port_b = 1'b1;
    // Observed outputs.
    logic [7:0] cnt, creg_a, creg_b;
    logic       down, ovf, flag_a, flag_b, wave_a, wave_b, pa_out, pa_oe, pb_out, pb_oe, lvl_a;
    int         mismatches = 0, checks = 0, highs;

    // 200 MHz clock.
    always #2.5 mclk = ~mclk;

    tmr8w_core DUT (
        .mclk(mclk), .srst(srst), .timer_tick(tick_en), .waveform_mode_field(mode),
        .compare_output_field_a(com_a), .compare_output_field_b(com_b),
        .compare_a_wdata(cmp_a_d), .compare_a_wr(cmp_a_we),
        .compare_b_wdata(cmp_b_d), .compare_b_wr(cmp_b_we),
        .counter_wdata(cnt_d), .counter_wr(cnt_we), .overflow_clr(flag_clr),
        .compare_flag_a_clr(flag_clr), .compare_flag_b_clr(flag_clr),
        .data_dir_a(dir_a), .data_dir_b(dir_b), .port_data_a(1'b0), .port_data_b(port_b),
        .counter_value(cnt), .count_down(down), .compare_register_a(creg_a),
        .compare_register_b(creg_b), .overflow_flag(ovf), .compare_flag_a(flag_a),
        .compare_flag_b(flag_b), .waveform_output_a(wave_a), .waveform_output_b(wave_b),
        .pin_a_out(pa_out), .pin_a_oe(pa_oe), .pin_b_out(pb_out), .pin_b_oe(pb_oe)
    );

    tmr8w_pin_model u_pin_a (.mclk(mclk), .pin_out(pa_out), .pin_oe(pa_oe), .pin_level(lvl_a));

    // ------------------------------------------------------------------------
    // Shared helpers.
    // ------------------------------------------------------------------------
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Inputs always move one nanosecond after the edge.
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Counter load also clears every sticky flag in the same cycle.
    task automatic load(input logic [7:0] v);
        cnt_d = v;
        cnt_we = 1'b1;
        flag_clr = 1'b1;
        step(1);
        cnt_we = 1'b0;
        flag_clr = 1'b0;
    endtask

    task automatic wr_a(input logic [7:0] v);
        cmp_a_d = v;
        cmp_a_we = 1'b1;
        step(1);
        cmp_a_we = 1'b0;
    endtask

    task automatic clr_flags();
        flag_clr = 1'b1;
        step(1);
        flag_clr = 1'b0;
    endtask

    // Counts the ticks on which output A is high.
    task automatic hi(input int n);
        highs = 0;
        repeat (n) begin
            if (wave_a === 1'b1) highs++;
            step(1);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------------
    task automatic t_reset();
        check(wave_a, 1'b0);
        check(wave_b, 1'b0);
        check(pa_oe, 1'b1);
        check(pb_oe, 1'b0);
    endtask

    task automatic t_ctc();
        mode = MODE_CTC;
        tick_en = 1'b1;
        wr_a(8'h03);
        cmp_b_d = 8'h02;
        cmp_b_we = 1'b1;
        step(1);
        cmp_b_we = 1'b0;
        load(8'h00);
        com_a = COM_TOGGLE;
        com_b = COM_SET;
        step(4);
        check(cnt, 8'h00);
        check(wave_a, 1'b1);
        check(lvl_a, 1'b1);
        check(flag_a, 1'b1);
        check(wave_b, 1'b1);
        check(flag_b, 1'b1);
        check(creg_b, 8'h02);
        // Ticks stop so that no fresh match races the clear.
        tick_en = 1'b0;
        clr_flags();
        tick_en = 1'b1;
        check(flag_a, 1'b0);
        // Starting above the top value forces a run through the wrap.
        load(8'h05);
        step(250);
        check(cnt, 8'hFF);
        step(1);
        check(cnt, 8'h00);
        check(ovf, 1'b1);
    endtask

    task automatic t_normal();
        logic [2:0] modes [3] = '{MODE_NORMAL, 3'h4, 3'h6};
        com_a = COM_SET;
        for (int i = 0; i < 3; i++) begin
            mode = modes[i];
            load(8'h02);
            step(2);
            check(cnt, 8'h04);
            step(252);
            check(cnt, 8'h00);
            check(ovf, 1'b1);
        end
    endtask

    task automatic t_fast();
        mode = MODE_FAST_MAX;
        com_a = COM_CLEAR;
        com_b = COM_TOGGLE;
        wr_a(8'h80);
        load(8'hFE);
        step(2);
        check(cnt, 8'h00);
        check(creg_a, 8'h80);
        check(wave_a, 1'b1);
        check(ovf, 1'b1);
        check(pb_out, port_b);
        step(8'h81);
        check(wave_a, 1'b0);
        com_a = COM_SET;
        step(8'h7F);
        check(wave_a, 1'b0);
        step(8'h81);
        check(wave_a, 1'b1);
        mode = MODE_FAST_OCR;
        com_a = COM_TOGGLE;
        load(8'h7E);
        step(3);
        check(cnt, 8'h00);
        check(wave_a, 1'b0);
    endtask

    task automatic t_pc();
        mode = MODE_PC_OCR;
        com_a = COM_CLEAR;
        load(8'h7E);
        step(3);
        check(cnt, 8'h7F);
        check(down, 1'b1);
        check(pb_out, port_b);
        mode = MODE_PC_MAX;
        wr_a(8'h40);
        step(382);
        check(cnt, 8'hFE);
        check(creg_a, 8'h40);
        clr_flags();
        step(8'hFD);
        check(ovf, 1'b1);
        check(wave_a, 1'b1);
        step(8'h41);
        check(wave_a, 1'b0);
        wr_a(8'h00);
        step(8'hBE);
        check(creg_a, 8'h00);
        hi(510);
        check(9'(highs), 9'h000);
    endtask

    task automatic t_spike();
        mode = MODE_FAST_MAX;
        // Channel B in inverting mode must be cleared by the bottom action.
        com_b = COM_SET;
        load(8'hFF);
        step(1);
        check(wave_a, 1'b1);
        check(wave_b, 1'b0);
        hi(256);
        check(9'(highs), 9'h001);
    endtask

    // Watchdog: a hang counts as a failure.
    initial begin
        #100us;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        step(5);
        srst = 1'b0;
        t_reset();
        t_ctc();
        t_normal();
        t_fast();
        t_pc();
        t_spike();
        tally_and_finish();
    end
endmodule

/* testbench/tmr8w_pin_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Port pin seen from outside the timer: driven level or a floating line.
// ----------------------------------------------------------------------------
module tmr8w_pin_model (
    input  wire logic mclk,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin_level
);
    // Wanders every cycle so that a stale level never passes for a driven one.
    logic float_q = 1'b0;

    // The floating pattern runs free; nothing outside drives this pin.
    always_ff @(posedge mclk) begin
        float_q <= ~float_q;
    end

    // Only a pin set as output shows the waveform state.
    assign pin_level = pin_oe ? pin_out : float_q;
endmodule
